// ---- design/bhop_defines.svh ----
// register offsets, field positions, reset values and symbol timing
// assumes inclusion by bare name from the band hopping design files
`ifndef BHOP_DEFINES_SVH
`define BHOP_DEFINES_SVH

// apb byte offsets
`define BHOP_CTRL_OFS 8'h00
`define BHOP_STATUS_OFS 8'h04
`define BHOP_TIMING_OFS 8'h08

// control fields
`define BHOP_CTRL_CHAN_LSB 0
`define BHOP_CTRL_BURST_BIT 8
`define BHOP_CTRL_LENZ_BIT 9
`define BHOP_CTRL_RESET 32'h0000_0009

// status fields
`define BHOP_ST_BAND_LSB 0
`define BHOP_ST_CODE_LSB 4
`define BHOP_ST_GROUP_LSB 7
`define BHOP_ST_VALID_BIT 10
`define BHOP_ST_HOP_BIT 11
`define BHOP_ST_FIXED_BIT 12
`define BHOP_ST_RXRDY_BIT 13
`define BHOP_ST_TXBUSY_BIT 14
`define BHOP_ST_POS_LSB 16

// symbol timing: the period in picoseconds, the rest counted in symbol periods
`define BHOP_SYMBOL_PERIOD_PS 312500
`define BHOP_MIN_GAP_TIME 6
`define BHOP_SHORT_GAP_TIME 32
`define BHOP_CHANNEL_CLEAR_WINDOW 18
`define BHOP_MAC_MIN_GAP `BHOP_MIN_GAP_TIME
`define BHOP_MAC_SHORT_GAP `BHOP_SHORT_GAP_TIME
`define BHOP_HOP_CYCLE 6

`endif

// ---- design/bhop_pkg.sv ----
// types shared by the band hopping and frame spacing block
// assumes nothing beyond a systemverilog compiler
package bhop_pkg;

   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h1,
      ST_EXACT = 4'h2,
      ST_MIN = 4'h4,
      ST_RXTURN = 4'h8
   } bhop_state_t;

   typedef struct packed
   {
      logic [7:0] channel;
      logic burst;
      logic len_zero;
      bhop_state_t st;
      logic [5:0] gap;
      logic [2:0] pos;
      logic [3:0] band;
      logic rx_ready;
      logic tx_busy;
      logic tx_go;
      logic [31:0] prdata;
      logic pslverr;
   } bhop_regs_t;

endpackage

// ---- design/bhop_pattern.sv ----
// channel decode and per-symbol band lookup, purely combinational
// assumes the caller registers the band before it leaves the chip
`timescale 1ns/1ps
module bhop_pattern
#(
   parameter logic [4:0] GROUP_EN = 5'h1F
)
(
   // selection
   input wire logic [7:0] channel,
   input wire logic [2:0] pos,
   // decode
   output logic valid,
   output logic [2:0] group,
   output logic [2:0] hop_code,
   output logic [3:0] band_index,
   output logic hopping_interleave_mode,
   output logic fixed_band_mode
);

   // band within a group, 1 to 3, for a code and symbol position
   function automatic logic [3:0] bhop_slot(input logic [2:0] code,
                                            input logic [2:0] p);
      logic [3:0] r;
      r = 4'h1;
      case (code)
         3'h1: r = (p == 3'h1 || p == 3'h4) ? 4'h2 :
                   (p == 3'h2 || p == 3'h5) ? 4'h3 : 4'h1;
         3'h2: r = (p == 3'h1 || p == 3'h4) ? 4'h3 :
                   (p == 3'h2 || p == 3'h5) ? 4'h2 : 4'h1;
         3'h3: r = (p < 3'h2) ? 4'h1 : (p < 3'h4) ? 4'h2 : 4'h3;
         3'h4: r = (p < 3'h2) ? 4'h1 : (p < 3'h4) ? 4'h3 : 4'h2;
         3'h5: r = 4'h1;
         3'h6: r = 4'h2;
         3'h7: r = 4'h3;
         default: r = 4'h1;
      endcase
      return r;
   endfunction

   logic grp_ok;

   always_comb
   begin
      group = channel[5:3];
      hop_code = channel[2:0];
      grp_ok = channel[7:6] == 2'h0 && group >= 3'h1 && group <= 3'h4 &&
               hop_code != 3'h0;
      if (group == 3'h5 && channel[7:6] == 2'h0)
         grp_ok = hop_code == 3'h5 || hop_code == 3'h6;
      valid = grp_ok && (group == 3'h1 || GROUP_EN[group - 3'h1]);
      band_index = 4'h0;
      if (valid)
         band_index = 4'((group - 3'h1) * 3) + bhop_slot(hop_code, pos);
      hopping_interleave_mode = valid && hop_code <= 3'h4;
      fixed_band_mode = valid && hop_code >= 3'h5;
   end

endmodule

// ---- design/bhop_top.sv ----
// band hopping sequencer and interframe spacing timer with apb registers
// assumes sym_tick pulses one cycle at each symbol leading edge and that
// tx_last and rx_last arrive together with such a tick
`timescale 1ns/1ps
`include "bhop_defines.svh"
module bhop_top
#(
   parameter logic [4:0] GROUP_EN = 5'h1F
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // symbol timing from the mac side
   input wire logic sym_tick,
   input wire logic pkt_start,
   input wire logic tx_req,
   input wire logic tx_last,
   input wire logic rx_last,
   // phy side results
   output logic tx_go,
   output logic rx_ready,
   output logic [3:0] band_index,
   output logic chan_valid,
   output logic hopping_interleave_mode,
   output logic fixed_band_mode
);

   localparam logic [5:0] MIN_LOAD = 6'(`BHOP_MAC_MIN_GAP + 1);
   localparam logic [5:0] SHORT_LOAD = 6'(`BHOP_MAC_SHORT_GAP + 1);
   localparam logic [2:0] POS_LAST = 3'(`BHOP_HOP_CYCLE - 1);

   localparam bhop_pkg::bhop_regs_t S_RESET = '{
      channel: 8'(`BHOP_CTRL_RESET),
      burst: 1'b0,
      len_zero: 1'b0,
      st: bhop_pkg::ST_IDLE,
      gap: 6'h00,
      pos: 3'h0,
      band: 4'h1,
      rx_ready: 1'b1,
      tx_busy: 1'b0,
      tx_go: 1'b0,
      prdata: 32'h0000_0000,
      pslverr: 1'b0
   };

   bhop_pkg::bhop_regs_t s;
   bhop_pkg::bhop_regs_t next_s;

   logic dec_valid;
   logic [2:0] dec_group;
   logic [2:0] dec_code;
   logic [3:0] dec_band;
   logic dec_hop;
   logic dec_fixed;
   logic start;
   logic go_now;
   logic wr;
   logic setup;

   bhop_pattern #(.GROUP_EN(GROUP_EN)) u_pattern
   (
      .channel(s.channel),
      .pos(next_s.pos),
      .valid(dec_valid),
      .group(dec_group),
      .hop_code(dec_code),
      .band_index(dec_band),
      .hopping_interleave_mode(dec_hop),
      .fixed_band_mode(dec_fixed)
   );

   function automatic logic bhop_mapped(input logic [7:0] a);
      return a == `BHOP_CTRL_OFS || a == `BHOP_STATUS_OFS ||
             a == `BHOP_TIMING_OFS;
   endfunction

   function automatic logic [31:0] bhop_read(input logic [7:0] a,
                                             input bhop_pkg::bhop_regs_t r,
                                             input logic [2:0] grp,
                                             input logic [2:0] code,
                                             input logic [2:0] flags);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         `BHOP_CTRL_OFS:
         begin
            d[`BHOP_CTRL_CHAN_LSB +: 8] = r.channel;
            d[`BHOP_CTRL_BURST_BIT] = r.burst;
            d[`BHOP_CTRL_LENZ_BIT] = r.len_zero;
         end
         `BHOP_STATUS_OFS:
         begin
            d[`BHOP_ST_BAND_LSB +: 4] = r.band;
            d[`BHOP_ST_CODE_LSB +: 3] = code;
            d[`BHOP_ST_GROUP_LSB +: 3] = grp;
            d[`BHOP_ST_VALID_BIT] = flags[0];
            d[`BHOP_ST_HOP_BIT] = flags[1];
            d[`BHOP_ST_FIXED_BIT] = flags[2];
            d[`BHOP_ST_RXRDY_BIT] = r.rx_ready;
            d[`BHOP_ST_TXBUSY_BIT] = r.tx_busy;
            d[`BHOP_ST_POS_LSB +: 3] = r.pos;
         end
         `BHOP_TIMING_OFS:
         begin
            d[5:0] = r.gap;
            d[11:8] = r.st;
            d[23:16] = 8'(`BHOP_CHANNEL_CLEAR_WINDOW);
         end
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   always_comb
   begin
      next_s = s;
      next_s.tx_go = 1'b0;
      setup = psel && !penable;
      wr = psel && penable && pwrite;
      go_now = 1'b0;

      // zero wait states: read data and error are ready by the access cycle
      if (setup)
      begin
         next_s.prdata = pwrite ? 32'h0000_0000 :
            bhop_read(paddr, s, dec_group, dec_code,
                      {dec_fixed, dec_hop, dec_valid});
         next_s.pslverr = !bhop_mapped(paddr);
      end
      if (wr && paddr == `BHOP_CTRL_OFS)
      begin
         next_s.channel = pwdata[`BHOP_CTRL_CHAN_LSB +: 8];
         next_s.burst = pwdata[`BHOP_CTRL_BURST_BIT];
         next_s.len_zero = pwdata[`BHOP_CTRL_LENZ_BIT];
      end

      if (sym_tick)
      begin
         case (s.st)
            bhop_pkg::ST_IDLE:
               go_now = tx_req && !s.tx_busy;
            bhop_pkg::ST_EXACT:
            begin
               next_s.gap = s.gap - 6'h01;
               if (s.gap <= 6'h01)
               begin
                  go_now = tx_req;
                  next_s.st = bhop_pkg::ST_IDLE;
               end
            end
            bhop_pkg::ST_MIN:
            begin
               next_s.gap = s.gap - 6'h01;
               if (s.gap <= 6'h01)
               begin
                  go_now = tx_req;
                  next_s.st = bhop_pkg::ST_IDLE;
               end
            end
            bhop_pkg::ST_RXTURN:
            begin
               next_s.gap = s.gap - 6'h01;
               go_now = tx_req;
               if (tx_req || s.gap <= 6'h01)
                  next_s.st = bhop_pkg::ST_IDLE;
            end
            default:
               next_s.st = bhop_pkg::ST_IDLE;
         endcase
         go_now = go_now && dec_valid;
         if (go_now)
         begin
            next_s.st = bhop_pkg::ST_IDLE;
            next_s.gap = 6'h00;
         end

         if (tx_last)
         begin
            if (s.burst)
            begin
               next_s.st = bhop_pkg::ST_EXACT;
               next_s.gap = MIN_LOAD;
            end
            else if (s.len_zero)
            begin
               next_s.st = bhop_pkg::ST_EXACT;
               next_s.gap = SHORT_LOAD;
            end
            else
            begin
               next_s.st = bhop_pkg::ST_MIN;
               next_s.gap = MIN_LOAD;
            end
            go_now = 1'b0;
         end
         else if (rx_last)
         begin
            next_s.st = bhop_pkg::ST_RXTURN;
            next_s.gap = SHORT_LOAD;
         end
      end

      next_s.tx_go = go_now;
      start = go_now || (sym_tick && pkt_start);

      if (start)
         next_s.pos = 3'h0;
      else if (sym_tick)
         next_s.pos = (s.pos == POS_LAST) ? 3'h0 : s.pos + 3'h1;

      if (go_now)
      begin
         next_s.tx_busy = 1'b1;
         next_s.rx_ready = 1'b0;
      end
      else if (sym_tick && tx_last)
         next_s.tx_busy = 1'b0;
      else if (sym_tick && !s.tx_busy)
         next_s.rx_ready = 1'b1;

      // band follows the position being entered this cycle
      next_s.band = dec_band;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s <= S_RESET;
      else
         s <= next_s;
   end

   assign pready = 1'b1;
   assign prdata = s.prdata;
   assign pslverr = s.pslverr && psel && penable;
   assign tx_go = s.tx_go;
   assign rx_ready = s.rx_ready;
   assign band_index = s.band;
   assign chan_valid = dec_valid;
   assign hopping_interleave_mode = dec_hop;
   assign fixed_band_mode = dec_fixed;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   band_range_a: assert property (
      chan_valid |-> band_index >= 4'h1 && band_index <= 4'hE ||
         $changed(s.channel) || $changed(s.pos))
      else $error("band index out of range for valid channel");

   reserved_chan_a: assert property (
      s.channel[7:6] != 2'h0 || s.channel[2:0] == 3'h0 |-> !chan_valid)
      else $error("reserved channel accepted");

   mandatory_chan_a: assert property (
      s.channel >= 8'h09 && s.channel <= 8'h0F |-> chan_valid)
      else $error("mandatory channel rejected");

   mode_class_a: assert property (
      chan_valid |-> hopping_interleave_mode != fixed_band_mode &&
         hopping_interleave_mode == (s.channel[2:0] <= 3'h4))
      else $error("interleave class wrong");

   burst_load_a: assert property (
      sym_tick && tx_last && s.burst |=>
         s.st == bhop_pkg::ST_EXACT && s.gap == 6'h07)
      else $error("burst gap not loaded with seven symbols");

   rx_load_a: assert property (
      sym_tick && rx_last && !tx_last |=>
         s.st == bhop_pkg::ST_RXTURN && s.gap == 6'h21)
      else $error("rx turnaround not loaded with 33 symbols");

   no_early_go_a: assert property (
      (s.st == bhop_pkg::ST_EXACT || s.st == bhop_pkg::ST_MIN) &&
         s.gap > 6'h01 |=> !tx_go)
      else $error("transmission started inside the gap");

   exact_slot_a: assert property (
      sym_tick && s.st == bhop_pkg::ST_EXACT && s.gap == 6'h01 &&
         tx_req && chan_valid && !tx_last |=> tx_go)
      else $error("exact slot missed");

   pos_wrap_a: assert property (
      sym_tick && !pkt_start && !go_now |=>
         s.pos == (($past(s.pos) == 3'h5) ? 3'h0 : $past(s.pos) + 3'h1))
      else $error("symbol position did not advance modulo six");

   rx_back_a: assert property (
      sym_tick && !s.tx_busy && !go_now |=> rx_ready)
      else $error("receiver not ready after transmission");

endmodule

// ---- sim/bhop_mac_model.sv ----
// mac side model: symbol ticks, transmit requests, last-symbol marks
// assumes one pclk domain; a tick comes every TICK_GAP+1 cycles
`timescale 1ns/1ps
module bhop_mac_model
#(
   parameter int TICK_GAP = 3
)
(
   // clock
   input wire logic pclk,
   // symbol link
   output logic sym_tick,
   output logic pkt_start,
   output logic tx_req,
   output logic tx_last,
   output logic rx_last
);
   initial
   begin
      sym_tick = 1'b0;
      pkt_start = 1'b0;
      tx_req = 1'b0;
      tx_last = 1'b0;
      rx_last = 1'b0;
   end

   // marks only ever travel with a tick, never alone
   task tick(input logic p, input logic tl, input logic rl);
      repeat (TICK_GAP) @(posedge pclk);
      sym_tick <= 1'b1;
      pkt_start <= p;
      tx_last <= tl;
      rx_last <= rl;
      @(posedge pclk);
      sym_tick <= 1'b0;
      pkt_start <= 1'b0;
      tx_last <= 1'b0;
      rx_last <= 1'b0;
   endtask

   task set_req(input logic v);
      @(posedge pclk);
      tx_req <= v;
   endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the band hopping and gap timer block
// assumes the mac model drives the symbol link; apb is driven here
`timescale 1ns/1ps
`include "bhop_defines.svh"
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic sym_tick, pkt_start, tx_req, tx_last, rx_last;
   logic tx_go, rx_ready, chan_valid, hop, fix;
   logic [3:0] band_index;
   int num_errors, num_checks, cycles, r, ch;
   int md [5] = '{1, 3, 2, 0, 0};
   int ex [5] = '{7, 7, 33, 7, 0};
   int pat [7][6] = '{'{1,2,3,1,2,3}, '{1,3,2,1,3,2}, '{1,1,2,2,3,3},
      '{1,1,3,3,2,2}, '{1,1,1,1,1,1}, '{2,2,2,2,2,2}, '{3,3,3,3,3,3}};

   bhop_top dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sym_tick(sym_tick),
      .pkt_start(pkt_start), .tx_req(tx_req), .tx_last(tx_last),
      .rx_last(rx_last), .tx_go(tx_go), .rx_ready(rx_ready),
      .band_index(band_index), .chan_valid(chan_valid),
      .hopping_interleave_mode(hop), .fixed_band_mode(fix)
   );

   bhop_mac_model mac
   (
      .pclk(pclk), .sym_tick(sym_tick), .pkt_start(pkt_start),
      .tx_req(tx_req), .tx_last(tx_last), .rx_last(rx_last)
   );

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // a hang ends the run as a failure
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         conclude();
      end
   end

   function automatic bit vld(int c);
      return (c >= 8 && c < 40 && c % 8 != 0) || c == 45 || c == 46;
   endfunction

   function automatic int eb(int c, int p);
      if (c / 8 == 5)
         return 8 + c % 8;
      return 3 * (c / 8 - 1) + pat[c % 8 - 1][p];
   endfunction

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task run_gap(input int from, input int exp, input bit rdy);
      int got;
      got = 0;
      for (int i = 1; i <= 40 && got == 0; i++)
      begin
         if (i == from)
            mac.set_req(1'b1);
         mac.tick(1'b0, 1'b0, 1'b0);
         #1;
         if (tx_go === 1'b1)
         begin
            got = i;
            chk(rx_ready, 1'b0);
            chk(band_index, eb(ch, 0));
         end
         else if (i == 1 && rdy)
            chk(rx_ready, 1'b1);
      end
      mac.set_req(1'b0);
      chk(got, exp);
   endtask

   task conclude();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      r = $urandom(29949);
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `BHOP_CTRL_OFS, 32'h0);
      chk(rd, `BHOP_CTRL_RESET);
      apb(1'b0, `BHOP_STATUS_OFS, 32'h0);
      chk(rd[14:10], 5'h0B);
      apb(1'b0, `BHOP_TIMING_OFS, 32'h0);
      chk(rd[23:16], `BHOP_CHANNEL_CLEAR_WINDOW);
      chk(rd[11:8], 4'h1);
      apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
      chk(err, 1'b1);
      apb(1'b1, `BHOP_STATUS_OFS, 32'h0);
      chk(err, 1'b0);
      apb(1'b0, `BHOP_CTRL_OFS, 32'h0);
      chk(rd, `BHOP_CTRL_RESET);
      $display("test reset done");
      // every channel number, with a full hop cycle on valid ones
      for (int c = 0; c < 256; c++)
      begin
         apb(1'b1, `BHOP_CTRL_OFS, c);
         chk(chan_valid, vld(c));
         if (vld(c))
         begin
            chk(hop, c % 8 <= 4);
            chk(fix, c % 8 >= 5);
            apb(1'b0, `BHOP_STATUS_OFS, 32'h0);
            chk(rd[9:4], c[5:0]);
            for (int k = 0; k < 8; k++)
            begin
               mac.tick(k == 0, 1'b0, 1'b0);
               #1;
               chk(band_index, eb(c, k % 6));
            end
         end
         else if (c == 0)
         begin
            mac.tick(1'b1, 1'b0, 1'b0);
            #1;
            chk(band_index, 4'h0);
         end
      end
      $display("test channel sweep done");
      ch = 9 + $urandom_range(6);
      apb(1'b1, `BHOP_CTRL_OFS, ch);
      run_gap(1, 1, 1'b0);
      for (int t = 0; t < 5; t++)
      begin
         apb(1'b1, `BHOP_CTRL_OFS, ch + 256 * md[t]);
         r = (t == 4) ? 8 + $urandom_range(12) : 1;
         mac.tick(1'b0, 1'b1, 1'b0);
         run_gap(r, (t == 4) ? r : ex[t], 1'b1);
      end
      $display("test tx spacing done");
      mac.tick(1'b0, 1'b1, 1'b0);
      repeat (40) mac.tick(1'b0, 1'b0, 1'b0);
      mac.tick(1'b0, 1'b0, 1'b1);
      r = 1 + $urandom_range(29);
      run_gap(r, r, 1'b0);
      $display("test rx turnaround done");
      conclude();
   end
endmodule
